// File: verilog/supervisor_pkg.sv
// Package of constants and carrier types for the supply supervisor.
`default_nettype none
package supervisor_pkg;

   // ==========================================================================
   // Timing constants
   localparam int unsigned CLK_HZ          = 200_000_000;
   localparam int unsigned TICK_HZ         = 30_000;
   localparam int unsigned TICK_CYC        = CLK_HZ / TICK_HZ;
   localparam int unsigned TICK_NS         = 1_000_000_000 / TICK_HZ;
   localparam int unsigned RESET_MS        = 25;
   localparam int unsigned WARN_MIN_US     = 200;
   localparam int unsigned WARN_MAX_US     = 500;
   localparam int unsigned GRACE_US        = 10;
   localparam int unsigned DEBOUNCE_TICKS  = 3;
   localparam int unsigned LOW_SAMPLES     = 3;
   // Tick counts, minimums rounded up.
   localparam int unsigned RESET_TICKS =
      (RESET_MS * 1_000_000 + TICK_NS - 1) / TICK_NS;
   localparam int unsigned WARN_TICKS =
      (WARN_MIN_US * 1_000 + TICK_NS - 1) / TICK_NS;
   localparam int unsigned GRACE_TICKS =
      (GRACE_US * 1_000 + TICK_NS - 1) / TICK_NS;
   localparam int unsigned CNT_W = 12;

   // ==========================================================================
   // Carrier types
   typedef struct packed {
      logic below_battery;   // Main supply under battery voltage.
      logic below_supply;    // Main supply under its trip level.
      logic sense_low;       // Sense point under its trip level.
      logic battery_present; // Battery attached.
   } supply_status_t;

   typedef enum logic [2:0] {
      PB_IDLE  = 3'b001,
      PB_PRESS = 3'b010,
      PB_HOLD  = 3'b100
   } pb_state_t;

   typedef enum logic [2:0] {
      CE_PASS  = 3'b001,
      CE_GRACE = 3'b010,
      CE_LOCK  = 3'b100
   } ce_state_t;

endpackage
`default_nettype wire

// File: verilog/supervisor_reset_warning_backup.sv
// Supervisor: pushbutton reset, power warning, memory protect, seal, power-fail.
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Overview
// All timing runs from one clock. A divider makes a one-cycle tick that
// stands for the slow sampling oscillator; every interval is a tick count.
// Supply comparator results arrive as levels and are taken as synchronous.
// A high select pin means a battery-backed processor, a low one a volatile one.
// The pushbutton path debounces a press over a few ticks, asserts the reset
// pair once the press is accepted, and times the interval from the release.
// The warning path filters the sense comparator over consecutive samples and
// gives one bounded pulse for each excursion below the sense trip level.
// In volatile mode the supply falling to its trip level also gives a pulse.
// The memory enable passes through while the supply is good, lets a running
// memory cycle finish within a short grace time on failure, and then stays
// inactive until the supply recovers.
// The seal keeps the switched supply off from battery attach to first power.
// The power-fail pair follows the battery crossing, one cycle late.
// ==========================================================================
// Limitations
// Comparator levels are outside this block; only their results come in.
// A supply that slews through the sense level faster than the filter span
// may give no warning pulse at all; the memory lock still follows.
// Reset is raised by the pushbutton only; other reset sources are elsewhere.
module supervisor_reset_warning_backup #(
   parameter int unsigned TICK_CYCLES = supervisor_pkg::TICK_CYC
) (
   // Clock and reset.
   input  wire logic                           clk_in,
   input  wire logic                           rst_b_in,
   // Supply comparator results.
   input  wire supervisor_pkg::supply_status_t supply_in,
   // Processor side.
   input  wire logic                           cpu_type_select_in,
   input  wire logic                           pushbutton_reset_n_in,
   output logic                                reset_out,
   output logic                                reset_n_out,
   output logic                                power_warn_n_out,
   output logic                                power_warn_oe_out,
   // Memory side.
   input  wire logic                           mem_enable_in_n_in,
   output logic                                mem_enable_out_n_out,
   output logic                                switched_supply_en_out,
   // Power-fail outputs.
   output logic                                power_fail_flag_out,
   output logic                                power_fail_flag_n_out
);

   // ==========================================================================
   // Parameter checks
   // The divider is sixteen bits wide and needs at least two cycles per tick.
   if (TICK_CYCLES < 2 || TICK_CYCLES > 65535) begin : g_bad_tick
      $error("TICK_CYCLES out of range");
   end
   // The interval counters must reach the longest tick count without wrapping.
   if (supervisor_pkg::RESET_TICKS >= (1 << supervisor_pkg::CNT_W)) begin : g_bad_cnt
      $error("CNT_W too narrow for the reset interval");
   end

   // ==========================================================================
   // State
   // All registered state lives in one packed struct, so the next-state logic
   // starts from a copy and changes only the fields that move.
   // The tick is registered too, so every user sees it on the same edge.
   typedef struct packed {
      logic [15:0]               div;
      logic                      tick;
      supervisor_pkg::pb_state_t pb;
      logic [supervisor_pkg::CNT_W-1:0] pb_cnt;
      logic [1:0]                low_cnt;
      logic                      warn_act;
      logic                      warn_done;
      logic [supervisor_pkg::CNT_W-1:0] warn_cnt;
      logic                      was_below_supply;
      logic                      supply_pulse;
      supervisor_pkg::ce_state_t ce;
      logic [supervisor_pkg::CNT_W-1:0] ce_cnt;
      logic                      ce_n;
      logic                      sealed;
      logic                      pf;
      logic                      rst_act;
      logic                      warn_oe;
   } state_t;

   state_t s_q;
   state_t s_d;

   logic battery_mode;
   logic pb_enabled;
   logic sense_low_gated;

   // ==========================================================================
   // Input qualifiers
   // The select pin is a strap, so its level is taken directly as the mode.
   assign battery_mode = cpu_type_select_in;
   // Pushbutton is honoured only when supply and mode allow it. Presses are
   // refused below battery, and while the sense input is low in battery-backed
   // mode, so a sleeping processor is not woken by the button.
   assign pb_enabled = !supply_in.below_battery
                       && !(supply_in.sense_low && battery_mode);
   // Low sense is held off while the supply is below trip level.
   // At power-up the sense comparator can read low long before the supply is
   // good; the gate keeps that from starting a pulse too early.
   assign sense_low_gated = supply_in.sense_low && !supply_in.below_supply;

   // ==========================================================================
   // Next-state logic.
   always_comb begin
      s_d = s_q;
      // Tick divider, one-cycle enable.
      // It stands in for the slow sampling oscillator; nothing runs slower.
      // Every interval in the block is a count of these ticks.
      s_d.tick = 1'b0;
      if (s_q.div == 16'(TICK_CYCLES - 1)) begin
         s_d.div  = 16'h0000;
         s_d.tick = 1'b1;
      end else begin
         s_d.div = s_q.div + 16'h0001;
      end

      // Pushbutton debounce and reset interval.
      // A press must stay low for the debounce span of ticks to count; a short
      // bounce returns to idle without touching the reset outputs. The interval
      // counts from the release, so a long press simply stretches the reset.
      // The press counter saturates so that a very long press cannot wrap it.
      unique case (s_q.pb)
         supervisor_pkg::PB_IDLE: begin
            s_d.pb_cnt = '0;
            if (!pushbutton_reset_n_in && pb_enabled) begin
               s_d.pb = supervisor_pkg::PB_PRESS;
            end
         end
         supervisor_pkg::PB_PRESS: begin
            if (pushbutton_reset_n_in || !pb_enabled) begin
               if (s_q.pb_cnt >= supervisor_pkg::CNT_W'(supervisor_pkg::DEBOUNCE_TICKS)) begin
                  s_d.pb     = supervisor_pkg::PB_HOLD;
                  s_d.pb_cnt = '0;
               end else begin
                  s_d.pb = supervisor_pkg::PB_IDLE;
               end
            end else if (s_q.tick && s_q.pb_cnt != '1) begin
               s_d.pb_cnt = s_q.pb_cnt + 1'b1;
            end
         end
         supervisor_pkg::PB_HOLD: begin
            if (s_q.tick) begin
               if (s_q.pb_cnt == supervisor_pkg::CNT_W'(supervisor_pkg::RESET_TICKS)) begin
                  s_d.pb = supervisor_pkg::PB_IDLE;
               end else begin
                  s_d.pb_cnt = s_q.pb_cnt + 1'b1;
               end
            end
         end
         default: s_d.pb = supervisor_pkg::PB_IDLE;
      endcase
      // Reset stays active through a debounced press and the whole interval.
      // It is worked out from the next state, so reset rises on the edge at which
      // the press is accepted and falls on the edge at which the interval ends.
      s_d.rst_act = (s_d.pb == supervisor_pkg::PB_HOLD)
                    || (s_d.pb == supervisor_pkg::PB_PRESS
                        && s_d.pb_cnt >= supervisor_pkg::CNT_W'(supervisor_pkg::DEBOUNCE_TICKS));

      // Warning filter: three consecutive low samples.
      // Any good sample clears the count, so noise shorter than the filter span
      // never reaches the pin. The count saturates while the level stays low.
      if (s_q.tick) begin
         if (!sense_low_gated) begin
            s_d.low_cnt = 2'h0;
         end else if (s_q.low_cnt != 2'(supervisor_pkg::LOW_SAMPLES)) begin
            s_d.low_cnt = s_q.low_cnt + 2'h1;
         end
      end
      // Supply trip in volatile mode also pulses the warning.
      // The previous supply level is kept so that only the falling crossing
      // starts a pulse, not a supply that simply stays below its trip level.
      s_d.was_below_supply = supply_in.below_supply;
      if (supply_in.below_supply && !s_q.was_below_supply && !battery_mode) begin
         s_d.supply_pulse = 1'b1;
      end else if (!supply_in.below_supply) begin
         s_d.supply_pulse = 1'b0;
      end
      // One pulse per excursion: warn_done blocks a second start until the
      // sense input is good again and no supply pulse is pending.
      if (!s_q.warn_act) begin
         if (!s_q.warn_done && ((s_q.tick && sense_low_gated
                && s_q.low_cnt == 2'(supervisor_pkg::LOW_SAMPLES - 1))
               || (s_q.supply_pulse && !supply_in.below_battery))) begin
            s_d.warn_act = 1'b1;
            s_d.warn_cnt = '0;
         end
         if (!sense_low_gated && !s_q.supply_pulse) begin
            s_d.warn_done = 1'b0;
         end
      end else begin
         // Pulse ends on timeout or when sense rises again.
         // The timeout counts one tick past the minimum so the pulse is never
         // short, and it stays well under the maximum.
         if (s_q.tick) begin
            s_d.warn_cnt = s_q.warn_cnt + 1'b1;
         end
         if ((s_q.tick && s_q.warn_cnt == supervisor_pkg::CNT_W'(supervisor_pkg::WARN_TICKS))
             || (!supply_in.sense_low && !s_q.supply_pulse)) begin
            s_d.warn_act     = 1'b0;
            s_d.warn_done    = 1'b1;
            s_d.supply_pulse = 1'b0;
         end
      end
      // Below battery the processor side is unpowered, so the pulse is dropped.
      if (supply_in.below_battery) begin
         s_d.warn_act = 1'b0;
      end
      // Output released in volatile mode below battery, else driven.
      // A volatile processor loses power there, so the pin must not drive into
      // it; a battery-backed one expects the pin held at its inactive level.
      s_d.warn_oe = !(supply_in.below_battery && !battery_mode);

      // Memory enable gating.
      // While the supply is good the enable follows its input one cycle late.
      // On failure a cycle already under way keeps its enable for the grace
      // time, so a write in progress is not cut in half; an idle enable is
      // locked at once. The lock lifts only when the supply is good again.
      unique case (s_q.ce)
         supervisor_pkg::CE_PASS: begin
            s_d.ce_n = mem_enable_in_n_in;
            if (supply_in.below_supply) begin
               s_d.ce_cnt = '0;
               if (!s_q.ce_n) begin
                  s_d.ce   = supervisor_pkg::CE_GRACE;
                  s_d.ce_n = s_q.ce_n;
               end else begin
                  s_d.ce   = supervisor_pkg::CE_LOCK;
                  s_d.ce_n = 1'b1;
               end
            end
         end
         // The grace count moves on ticks, so the lock follows within one tick.
         supervisor_pkg::CE_GRACE: begin
            if (s_q.tick) begin
               s_d.ce_cnt = s_q.ce_cnt + 1'b1;
            end
            if (mem_enable_in_n_in
                || s_q.ce_cnt == supervisor_pkg::CNT_W'(supervisor_pkg::GRACE_TICKS)) begin
               s_d.ce   = supervisor_pkg::CE_LOCK;
               s_d.ce_n = 1'b1;
            end
         end
         supervisor_pkg::CE_LOCK: begin
            s_d.ce_n = 1'b1;
            if (!supply_in.below_supply) begin
               s_d.ce   = supervisor_pkg::CE_PASS;
               s_d.ce_n = mem_enable_in_n_in;
            end
         end
         default: s_d.ce = supervisor_pkg::CE_LOCK;
      endcase

      // Freshness seal.
      // Removing the battery sets the seal again, and only main power above
      // battery clears it, so a fresh battery is not drained on the shelf.
      if (!supply_in.battery_present) begin
         s_d.sealed = 1'b1;
      end else if (!supply_in.below_battery) begin
         s_d.sealed = 1'b0;
      end

      // Power-fail at the battery crossing.
      // It follows the crossing in both directions, one cycle after the input.
      s_d.pf = supply_in.below_battery;
   end

   // ==========================================================================
   // State register.
   // Reset puts every output at its inactive or safe level.
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s_q         <= '0;
         // The last supply level resets high, so a supply that is still below
         // its trip level at release is not taken for a falling crossing.
         s_q.was_below_supply <= 1'b1;
         s_q.pb      <= supervisor_pkg::PB_IDLE;
         s_q.ce      <= supervisor_pkg::CE_LOCK;
         s_q.ce_n    <= 1'b1;
         s_q.sealed  <= 1'b1;
         s_q.pf      <= 1'b1;
         s_q.warn_oe <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================================
   // Outputs
   // Outputs from registers, or their inverses, so none of them can glitch.
   assign reset_out              = s_q.rst_act;
   assign reset_n_out            = !s_q.rst_act;
   assign power_warn_n_out       = !s_q.warn_act;
   assign power_warn_oe_out      = s_q.warn_oe;
   assign mem_enable_out_n_out   = s_q.ce_n;
   assign switched_supply_en_out = !s_q.sealed;
   assign power_fail_flag_out    = s_q.pf;
   assign power_fail_flag_n_out  = !s_q.pf;

endmodule // supervisor_reset_warning_backup
`default_nettype wire

// File: tb/supervisor_monitor.sv
// Checker that watches the supervisor top-level ports.
`timescale 1ns/100ps
`default_nettype none
module supervisor_monitor #(
   parameter int unsigned TICK_CYCLES = 4
) (
   // Clock, reset and inputs.
   input wire logic                   clk_in,
   input wire logic                   rst_b_in,
   input wire supervisor_pkg::supply_status_t supply_in,
   input wire logic                   cpu_type_select_in,
   input wire logic                   pushbutton_reset_n_in,
   input wire logic                   mem_enable_in_n_in,
   // Outputs of the block.
   input wire logic                   reset_out,
   input wire logic                   reset_n_out,
   input wire logic                   power_warn_n_out,
   input wire logic                   power_warn_oe_out,
   input wire logic                   mem_enable_out_n_out,
   input wire logic                   switched_supply_en_out,
   input wire logic                   power_fail_flag_out,
   input wire logic                   power_fail_flag_n_out
);
   localparam int RST_LO = 750 * TICK_CYCLES;
   localparam int RST_HI = 900 * TICK_CYCLES;
   logic [15:0] rel_q;
   // Counts cycles since the button was last released, saturating.
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rel_q <= 16'h0000;
      end else begin
         rel_q <= pushbutton_reset_n_in ? rel_q + {15'h0000, ~&rel_q} : 16'h0000;
      end
   end
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_b_in);
   a_reset_hold_span: assert property (
      $fell(reset_out) |-> rel_q >= RST_LO && rel_q <= RST_HI) else $error("reset span wrong");
   a_button_lock_out: assert property (
      (supply_in.below_battery || (cpu_type_select_in && supply_in.sense_low)) && !reset_out
      |=> !reset_out) else $error("blocked press gave reset");
   a_flag_follow_bat: assert property (##1 power_fail_flag_out == $past(supply_in.below_battery)
      && power_fail_flag_n_out != power_fail_flag_out) else $error("power-fail flags wrong");
   a_mem_pass_thru: assert property ((!supply_in.below_supply)[*3]
      |=> mem_enable_out_n_out == $past(mem_enable_in_n_in)) else $error("memory enable not passed");
   a_mem_lock_idle: assert property (supply_in.below_supply && mem_enable_out_n_out
      |=> mem_enable_out_n_out) else $error("memory enable unlocked");
   a_mem_grace_end: assert property ((supply_in.below_supply)[*8] ##1
      (supply_in.below_supply)[*3] |-> mem_enable_out_n_out) else $error("grace too long");
   a_warn_three_low: assert property ($fell(power_warn_n_out) && cpu_type_select_in
      |-> $past(supply_in.sense_low, 8) && !$past(supply_in.below_supply)) else $error("early warning");
   a_warn_min_low: assert property ($fell(power_warn_n_out)
      |=> (!power_warn_n_out || !supply_in.sense_low)[*8]) else $error("warning too short");
   a_warn_pin_drive: assert property (
      (supply_in.below_battery && $stable(cpu_type_select_in))[*2]
      |-> power_warn_n_out && power_warn_oe_out == cpu_type_select_in) else $error("warning pin wrong");
   c_button_reset: cover property ($fell(reset_out));
   c_warn_pulse: cover property ($rose(power_warn_n_out));
   c_mem_locked: cover property (supply_in.below_supply && $rose(mem_enable_out_n_out));
endmodule // supervisor_monitor
bind supervisor_reset_warning_backup supervisor_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon_i (
   .clk_in(clk_in), .rst_b_in(rst_b_in), .supply_in(supply_in),
   .cpu_type_select_in(cpu_type_select_in), .pushbutton_reset_n_in(pushbutton_reset_n_in),
   .mem_enable_in_n_in(mem_enable_in_n_in), .reset_out(reset_out), .reset_n_out(reset_n_out),
   .power_warn_n_out(power_warn_n_out), .power_warn_oe_out(power_warn_oe_out),
   .mem_enable_out_n_out(mem_enable_out_n_out), .switched_supply_en_out(switched_supply_en_out),
   .power_fail_flag_out(power_fail_flag_out), .power_fail_flag_n_out(power_fail_flag_n_out));
`default_nettype wire

// File: tb/cpu_sram_model.sv
// Processor and memory model: mode strap and memory cycles.
`timescale 1ns/100ps
`default_nettype none
module cpu_sram_model (
   // Clock and reset.
   input  wire logic       clk_in,
   input  wire logic       rst_b_in,
   // Scenario controls.
   input  wire logic       backed_in,
   input  wire logic       start_in,
   input  wire logic [7:0] cycle_len_in,
   // Pins toward the supervisor.
   output logic            cpu_type_select_out,
   output logic            mem_enable_in_n_out
);
   logic [7:0] left_q;
   // The select pin is strapped high for a battery-backed processor.
   assign cpu_type_select_out = backed_in;
   // Holds the memory enable low for the requested number of cycles.
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         left_q <= 8'h00;
      end else if (start_in) begin
         left_q <= cycle_len_in;
      end else if (left_q != 8'h00) begin
         left_q <= left_q - 8'h01;
      end
   end
   assign mem_enable_in_n_out = (left_q == 8'h00);
endmodule // cpu_sram_model
`default_nettype wire

// File: tb/tb_supervisor_reset_warning_backup.sv
// Testbench for the supply supervisor block.
`timescale 1ns/100ps
`default_nettype none
module tb_supervisor_reset_warning_backup;
   localparam int TC = 4;
   logic clk = 1'h0;
   logic rst_b = 1'h0;
   supervisor_pkg::supply_status_t sup = 4'hf;
   logic pb_n = 1'h1;
   logic backed = 1'h0;
   logic start = 1'h0;
   logic [7:0] len = 8'h05;
   logic sel, mem_in, rst_o, rst_n_o, warn_n, oe, mem_o, sw_en, pf, pf_n;
   int miscompares = 0;
   int checks = 0;
   cpu_sram_model cpu_sram_model_i (.clk_in(clk), .rst_b_in(rst_b), .backed_in(backed),
      .start_in(start), .cycle_len_in(len), .cpu_type_select_out(sel),
      .mem_enable_in_n_out(mem_in));
   supervisor_reset_warning_backup #(.TICK_CYCLES(TC)) supervisor_reset_warning_backup_i (
      .clk_in(clk), .rst_b_in(rst_b), .supply_in(sup), .cpu_type_select_in(sel),
      .pushbutton_reset_n_in(pb_n), .reset_out(rst_o), .reset_n_out(rst_n_o),
      .power_warn_n_out(warn_n), .power_warn_oe_out(oe), .mem_enable_in_n_in(mem_in),
      .mem_enable_out_n_out(mem_o), .switched_supply_en_out(sw_en),
      .power_fail_flag_out(pf), .power_fail_flag_n_out(pf_n));
   // Makes the 200 MHz clock.
   initial begin
      forever #2.5 clk = ~clk;
   end
   // Compares one bit and reports a mismatch.
   task automatic cmp(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Waits n edges, then steps just past the last one.
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Waits up to lim cycles for a warning, then counts its low cycles.
   task automatic warn_len(input int lim, output int n);
      n = 0;
      while (warn_n === 1'h1 && lim > 0) begin
         cyc(1);
         lim--;
      end
      while (warn_n === 1'h0 && n < 100) begin
         cyc(1);
         n++;
      end
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic report_and_stop();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Power-up from battery: seal, flags, warning held off, then timed out.
   task automatic t_powerup();
      int n;
      cyc(2);
      cmp(sw_en, 1'h0);
      cmp(pf, 1'h1);
      sup.below_battery = 1'h0;
      cyc(2);
      cmp(sw_en, 1'h1);
      cmp(pf_n, 1'h1);
      warn_len(6 * TC, n);
      cmp(n == 0, 1'h1);
      sup.below_supply = 1'h0;
      warn_len(6 * TC, n);
      cmp(n >= 6 * TC && n <= 15 * TC, 1'h1);
      sup.sense_low = 1'h0;
      // Lets a tick see the good level so the filter and the one-shot re-arm.
      cyc(TC);
      $display("done powerup");
   endtask
   // Short noise is filtered; a held low times out; a rise ends the pulse.
   task automatic t_warn();
      int n;
      backed = 1'h1;
      sup.sense_low = 1'h1;
      cyc(2 * TC);
      sup.sense_low = 1'h0;
      warn_len(3 * TC, n);
      cmp(n == 0, 1'h1);
      sup.sense_low = 1'h1;
      pb_n = 1'h0;
      warn_len(5 * TC, n);
      pb_n = 1'h1;
      cmp(n >= 6 * TC && n <= 15 * TC, 1'h1);
      cmp(rst_o, 1'h0);
      sup.sense_low = 1'h0;
      cyc(TC);
      sup.sense_low = 1'h1;
      cyc(3 * TC + 2);
      cmp(warn_n, 1'h0);
      sup.sense_low = 1'h0;
      cyc(2);
      cmp(warn_n, 1'h1);
      $display("done warn");
   endtask
   // A long press; the reset interval is timed from release.
   task automatic t_button();
      int n;
      backed = 1'h0;
      pb_n = 1'h0;
      cyc(6 * TC);
      cmp(rst_o, 1'h1);
      cmp(rst_n_o, 1'h0);
      cyc(100 * TC);
      pb_n = 1'h1;
      n = 0;
      while (rst_o === 1'h1 && n < 900 * TC) begin
         cyc(1);
         n++;
      end
      cmp(n >= 750 * TC && n < 900 * TC, 1'h1);
      cmp(rst_n_o, 1'h1);
      $display("done button");
   endtask
   // Supply collapse: warning per mode, memory protect, button lock-out, pin drive.
   task automatic t_low_supply();
      int n;
      cyc(2);
      cmp(mem_o, 1'h1);
      sup.below_supply = 1'h1;
      warn_len(6 * TC, n);
      cmp(n >= 6 * TC && n <= 15 * TC, 1'h1);
      start = 1'h1;
      cyc(1);
      start = 1'h0;
      cyc(3);
      cmp(mem_o, 1'h1);
      sup.below_supply = 1'h0;
      backed = 1'h1;
      len = 8'hc8;
      cyc(8);
      start = 1'h1;
      cyc(1);
      start = 1'h0;
      cyc(2);
      cmp(mem_o, 1'h0);
      sup.below_supply = 1'h1;
      cyc(1);
      cmp(mem_o, 1'h0);
      cyc(12);
      cmp(mem_o, 1'h1);
      warn_len(3 * TC, n);
      cmp(n == 0, 1'h1);
      sup.below_battery = 1'h1;
      pb_n = 1'h0;
      cyc(6 * TC);
      pb_n = 1'h1;
      cmp(rst_o, 1'h0);
      cmp(oe, 1'h1);
      cmp(warn_n, 1'h1);
      backed = 1'h0;
      cyc(2);
      cmp(oe, 1'h0);
      cmp(sw_en, 1'h1);
      cmp(pf, 1'h1);
      sup.battery_present = 1'h0;
      cyc(2);
      cmp(sw_en, 1'h0);
      sup.battery_present = 1'h1;
      cyc(2);
      cmp(sw_en, 1'h0);
      $display("done low supply");
   endtask
   // Cuts a hang short well past the expected run length.
   initial begin
      #200_000;
      miscompares++;
      report_and_stop();
   end
   // Holds reset for ten cycles, then runs the scenarios.
   initial begin
      repeat (10) @(posedge clk);
      #1;
      rst_b = 1'h1;
      t_powerup();
      t_warn();
      t_button();
      t_low_supply();
      report_and_stop();
   end
endmodule // tb_supervisor_reset_warning_backup
`default_nettype wire
